// [inc/rsl_pkg.sv]
// constants and types shared by the rate-select / loopback ends
package rsl_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LOCK_TIME_US  = 500;
  // a longest time: round down to whole cycles, at least one
  localparam int LOCK_CYCLES_CALC = (LOCK_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int LOCK_CYCLES  = (LOCK_CYCLES_CALC < 1) ? 1 : LOCK_CYCLES_CALC;
  localparam int LOCK_CNT_W   = 17;

  // ---------------------------------------------------------------
  // option word carried over the two-wire control path
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       opticalLoopback;
    logic       electricalLoopback;
    logic       passThrough;
    logic [2:0] txEq;
    logic [2:0] rxEmphasis;
  } rsl_opts_t;

  localparam rsl_opts_t OPTS_RESET = '{default: 1'b0};

  // device status word bit positions
  localparam int STAT_RX_LOCK   = 0;
  localparam int STAT_TX_LOCK   = 1;
  localparam int STAT_RX_ENGAGE = 2;
  localparam int STAT_TX_ENGAGE = 3;
  localparam int STAT_W         = 4;

  // ---------------------------------------------------------------
  // host controller register map (APB, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_SELECT  = 12'h000;
  localparam logic [11:0] REG_OPTIONS = 12'h004;
  localparam logic [11:0] REG_STATUS  = 12'h008;
  localparam logic [11:0] REG_DATA    = 12'h00c;

  // SELECT fields
  localparam int SEL_RX    = 0;
  localparam int SEL_TX    = 1;
  localparam int SEL_DRIVE = 2;
  localparam logic [2:0] SELECT_RESET = 3'h0;
  // OPTIONS fields: word [8:0] is rsl_opts_t
  localparam int OPT_W = 9;
  // DATA fields
  localparam int DAT_TX_BIT   = 0;
  localparam int DAT_TOP_RATE = 1;
  localparam int DAT_RX_BIT   = 2;

endpackage : rsl_pkg

// [inc/rsl_link_if.sv]
// link between the host controller and the transceiver control block
`timescale 1ns/1ps
`default_nettype none

interface rsl_link_if;
  import rsl_pkg::*;

  logic            rxSelDrive;
  logic            rxSelEn;
  logic            txSelDrive;
  logic            txSelEn;
  logic            rxSpeedSelect;
  logic            txSpeedSelect;
  logic            hostSerialInput;
  logic            hostTopRate;
  logic            hostSerialOutput;
  logic            ctrlValid;
  rsl_opts_t       ctrlWord;
  logic [STAT_W-1:0] devStatus;

  // selects are pulled down inside the device: an undriven pin reads low
  assign rxSpeedSelect = rxSelEn ? rxSelDrive : 1'b0;
  assign txSpeedSelect = txSelEn ? txSelDrive : 1'b0;

  modport device (
    input  rxSpeedSelect,
    input  txSpeedSelect,
    input  hostSerialInput,
    input  hostTopRate,
    input  ctrlValid,
    input  ctrlWord,
    output hostSerialOutput,
    output devStatus
  );

  modport host (
    output rxSelDrive,
    output rxSelEn,
    output txSelDrive,
    output txSelEn,
    output hostSerialInput,
    output hostTopRate,
    output ctrlValid,
    output ctrlWord,
    input  hostSerialOutput,
    input  devStatus
  );

endinterface : rsl_link_if

`default_nettype wire

// [core/rsl_device.sv]
// transceiver end: rate select, clock recovery lock, wrap and EQ control
// ---------------------------------------------------------------
// Notes on behaviour
// - rx select high engages rx recovery, locks
// - lock reported only on top-rate traffic
// - rx select low bypasses rx recovery
// - tx select high engages tx recovery, locks
// - tx select low bypasses tx recovery
// - rx and tx selects honoured independently
// - host sets both selects equal after negotiation; rsl_host leaves both select bits to software, equal or not
// - optical wrap retimes and resends optical data
// - electrical wrap retimes and returns host data
// - pass-through also sends wrapped data outbound
// - host-selected input equalisation applied
// - host-selected output emphasis applied
// - host may tune emphasis through wraps
// - undriven selects read low
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module rsl_device
  import rsl_pkg::*;
#(
  parameter int LOCK_DELAY = LOCK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  rsl_link_if.device      link,
  input  wire logic       opticalIn,
  input  wire logic       opticalTopRate,
  output logic            opticalOut,
  output logic            rxLocked,
  output logic            txLocked,
  output logic            rxEngaged,
  output logic            txEngaged,
  output logic [2:0]      txEqSetting,
  output logic [2:0]      rxEmphasisSetting
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // the count runs from zero, so lock shows on the edge after the
  // count reaches its last value
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
    LOCK_CNT_W'(LOCK_DELAY - 1);

  typedef struct packed {
    logic [1:0]            rxSelPipe;
    logic [1:0]            txSelPipe;
    logic [1:0]            rxRatePipe;
    logic                  rxSelPrev;
    logic                  txSelPrev;
    logic [LOCK_CNT_W-1:0] rxCount;
    logic [LOCK_CNT_W-1:0] txCount;
    logic                  rxLocked;
    logic                  txLocked;
    rsl_opts_t             opts;
    logic                  rxCdr;
    logic                  txCdr;
    logic                  hostOut;
    logic                  opticalOut;
    logic [STAT_W-1:0]     status;
  } rsl_dev_state_t;

  rsl_dev_state_t st;
  rsl_dev_state_t next_st;

  // ---------------------------------------------------------------
  // lock tracker shared by both recovery stages
  // ---------------------------------------------------------------
  // returns {lock, count}; any loss of engagement or traffic restarts
  // restarting on every select change trades a slower relock for a
  // simple rule: a stale count can never report lock early
  function automatic logic [LOCK_CNT_W:0] lock_step(
    input logic                  engaged,
    input logic                  changed,
    input logic                  topRate,
    input logic [LOCK_CNT_W-1:0] count,
    input logic                  locked
  );
    logic [LOCK_CNT_W:0] res;
    res = '0;
    if (!engaged || changed || !topRate) begin
      res = '0;
    end else if (locked) begin
      res = {1'b1, count};
    end else if (count == LOCK_LAST) begin
      res = {1'b1, count};
    end else begin
      res = {1'b0, count + LOCK_CNT_W'(1)};
    end
    return res;
  endfunction : lock_step

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic rxSel;
  logic txSel;
  logic rxChanged;
  logic txChanged;
  logic anyWrap;
  logic rxTopRate;

  assign rxTopRate = st.rxRatePipe[1];
  assign rxSel     = st.rxSelPipe[1];
  assign txSel     = st.txSelPipe[1];
  assign rxChanged = rxSel != st.rxSelPrev;
  assign txChanged = txSel != st.txSelPrev;
  assign anyWrap   = st.opts.opticalLoopback | st.opts.electricalLoopback;

  always_comb begin
    next_st = st;

    // pins are asynchronous to core_clk: two flops before use
    // an undriven pin arrives low and leaves recovery bypassed
    next_st.rxSelPipe = {st.rxSelPipe[0], link.rxSpeedSelect};
    next_st.txSelPipe = {st.txSelPipe[0], link.txSpeedSelect};
    // the fibre traffic flag is a pin as well; its flops only delay lock
    next_st.rxRatePipe = {st.rxRatePipe[0], opticalTopRate};
    next_st.rxSelPrev = rxSel;
    next_st.txSelPrev = txSel;

    // each side follows its own select only
    {next_st.rxLocked, next_st.rxCount} = lock_step(
      rxSel, rxChanged, rxTopRate, st.rxCount, st.rxLocked);
    // the host traffic flag comes from logic on this clock: no flops
    {next_st.txLocked, next_st.txCount} = lock_step(
      txSel, txChanged, link.hostTopRate, st.txCount, st.txLocked);

    // options arrive as whole words from the two-wire control path
    // a new word replaces the whole set; fields never merge
    if (link.ctrlValid) begin
      next_st.opts = link.ctrlWord;
    end

    // recovery retiming stage, one cycle of extra latency
    // bypass keeps one cycle so a legacy-rate host sees no extra delay
    // electrical wrap wins toward the host and optical toward the
    // fibre, so with both set each port still carries retimed data
    next_st.rxCdr = opticalIn;
    next_st.txCdr = link.hostSerialInput;

    // toward the host
    if (st.opts.electricalLoopback) begin
      next_st.hostOut = st.txCdr;
    end else if (st.opts.opticalLoopback) begin
      next_st.hostOut = st.opts.passThrough ? st.rxCdr : 1'b0;
    end else if (rxSel) begin
      next_st.hostOut = st.rxCdr;
    end else begin
      next_st.hostOut = opticalIn;
    end

    // toward the fibre
    if (st.opts.opticalLoopback) begin
      next_st.opticalOut = st.rxCdr;
    end else if (st.opts.electricalLoopback) begin
      next_st.opticalOut = st.opts.passThrough ? st.txCdr : 1'b0;
    end else if (txSel) begin
      next_st.opticalOut = st.txCdr;
    end else begin
      next_st.opticalOut = link.hostSerialInput;
    end

    // status seen by the host, one cycle behind the lock flags
    // engaged also counts a wrap: a wrap always runs through recovery
    next_st.status = '0;
    next_st.status[STAT_RX_LOCK]   = st.rxLocked;
    next_st.status[STAT_TX_LOCK]   = st.txLocked;
    next_st.status[STAT_RX_ENGAGE] = rxSel | anyWrap;
    next_st.status[STAT_TX_ENGAGE] = txSel | anyWrap;

    // reset also empties the pin flops, so no stale select survives it
    if (sys_rst) begin
      next_st = '{default: '0};
      next_st.opts = OPTS_RESET;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign link.hostSerialOutput = st.hostOut;
  assign link.devStatus        = st.status;
  assign opticalOut            = st.opticalOut;
  assign rxLocked              = st.rxLocked;
  assign txLocked              = st.txLocked;
  assign rxEngaged             = st.status[STAT_RX_ENGAGE];
  assign txEngaged             = st.status[STAT_TX_ENGAGE];
  // eq and emphasis only shape analog stages; exposed for the pads
  assign txEqSetting           = st.opts.txEq;
  assign rxEmphasisSetting     = st.opts.rxEmphasis;

endmodule : rsl_device

`default_nettype wire

// [core/rsl_host.sv]
// host end: APB registers driving the selects, options and test data
`timescale 1ns/1ps
`default_nettype none

module rsl_host
  import rsl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  rsl_link_if.host         link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  select;
    rsl_opts_t   opts;
    logic        ctrlValid;
    logic        txBit;
    logic        topRate;
    logic [31:0] rdata;
    logic        slvErr;
  } rsl_host_state_t;

  rsl_host_state_t st;
  rsl_host_state_t next_st;

  logic setup;
  logic access;
  logic mapped;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == REG_SELECT) | (paddr == REG_OPTIONS) |
                  (paddr == REG_STATUS) | (paddr == REG_DATA);

  // ---------------------------------------------------------------
  // register access: zero wait, read data prepared in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ctrlValid = 1'b0;

    if (setup) begin
      next_st.slvErr = ~mapped;
      next_st.rdata  = '0;
      if (!pwrite) begin
        case (paddr)
          REG_SELECT:  next_st.rdata[2:0] = st.select;
          REG_OPTIONS: next_st.rdata[OPT_W-1:0] = st.opts;
          REG_STATUS:  next_st.rdata[STAT_W-1:0] = link.devStatus;
          REG_DATA: begin
            next_st.rdata[DAT_TX_BIT]   = st.txBit;
            next_st.rdata[DAT_TOP_RATE] = st.topRate;
            // sampled looped traffic lets software tune emphasis
            next_st.rdata[DAT_RX_BIT]   = link.hostSerialOutput;
          end
          default:     next_st.rdata = '0;
        endcase
      end
    end

    if (access && pwrite) begin
      case (paddr)
        // software owns when rx and tx selects differ or match
        REG_SELECT:  next_st.select = pwdata[2:0];
        REG_OPTIONS: begin
          next_st.opts      = rsl_opts_t'(pwdata[OPT_W-1:0]);
          next_st.ctrlValid = 1'b1;
        end
        REG_DATA: begin
          next_st.txBit   = pwdata[DAT_TX_BIT];
          next_st.topRate = pwdata[DAT_TOP_RATE];
        end
        default: next_st.select = st.select;
      endcase
    end

    if (sys_rst) begin
      next_st = '{default: '0};
      next_st.select = SELECT_RESET;
      next_st.opts   = OPTS_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata  = st.rdata;
  assign pslverr = st.slvErr;
  assign pready  = 1'b1;

  // with drive off the select pins float and the device sees low
  assign link.rxSelDrive      = st.select[SEL_RX];
  assign link.txSelDrive      = st.select[SEL_TX];
  assign link.rxSelEn         = st.select[SEL_DRIVE];
  assign link.txSelEn         = st.select[SEL_DRIVE];
  assign link.hostSerialInput = st.txBit;
  assign link.hostTopRate     = st.topRate;
  assign link.ctrlValid       = st.ctrlValid;
  assign link.ctrlWord        = st.opts;

endmodule : rsl_host

`default_nettype wire

// [verification/rsl_checker.sv]
// link checker: select, lock and wrap relations
`timescale 1ns/1ps
`default_nettype none

module rsl_checker
  import rsl_pkg::*;
#(
  parameter int LOCK_DELAY = 16
) (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              rxSpeedSelect,
  input wire logic              txSpeedSelect,
  input wire logic              hostSerialInput,
  input wire logic              hostTopRate,
  input wire logic              hostSerialOutput,
  input wire logic              ctrlValid,
  input wire rsl_opts_t         ctrlWord,
  input wire logic [STAT_W-1:0] devStatus
);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  rsl_opts_t  opts;
  logic [7:0] age;
  logic [7:0] txRun;

  // counters saturate so long idle stretches never wrap round
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opts  <= OPTS_RESET;
      age   <= 8'h00;
      txRun <= 8'h00;
    end else begin
      opts  <= ctrlValid ? ctrlWord : opts;
      age   <= ctrlValid ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
      txRun <= !(txSpeedSelect && hostTopRate) ? 8'h00 :
               (txRun == 8'hff ? txRun : txRun + 8'h01);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_rxLowNoLock;
    !rxSpeedSelect [*5] |-> !devStatus[STAT_RX_LOCK];
  endproperty
  a_rxLowNoLock: assert property (p_rxLowNoLock)
    else $error("rx lock while select low");
  property p_txLowNoLock;
    !txSpeedSelect [*5] |-> !devStatus[STAT_TX_LOCK];
  endproperty
  a_txLowNoLock: assert property (p_txLowNoLock)
    else $error("tx lock while select low");
  property p_rxChangeClears;
    $changed(rxSpeedSelect) |-> ##[1:6] !devStatus[STAT_RX_LOCK];
  endproperty
  a_rxChangeClears: assert property (p_rxChangeClears)
    else $error("rx lock kept over select change");
  property p_txChangeClears;
    $changed(txSpeedSelect) |-> ##[1:6] !devStatus[STAT_TX_LOCK];
  endproperty
  a_txChangeClears: assert property (p_txChangeClears)
    else $error("tx lock kept over select change");
  property p_rxEngage;
    rxSpeedSelect [*6] |-> devStatus[STAT_RX_ENGAGE];
  endproperty
  a_rxEngage: assert property (p_rxEngage)
    else $error("rx recovery not engaged");
  property p_txEngage;
    txSpeedSelect [*6] |-> devStatus[STAT_TX_ENGAGE];
  endproperty
  a_txEngage: assert property (p_txEngage)
    else $error("tx recovery not engaged");
  property p_txLockBound;
    int'(txRun) > LOCK_DELAY + 8 |-> devStatus[STAT_TX_LOCK];
  endproperty
  a_txLockBound: assert property (p_txLockBound)
    else $error("tx lock late");
  property p_txSlowNoLock;
    !hostTopRate [*5] |-> !devStatus[STAT_TX_LOCK];
  endproperty
  a_txSlowNoLock: assert property (p_txSlowNoLock)
    else $error("tx locked on lower rate");
  property p_ewrapData;
    opts.electricalLoopback && age > 8'h04
      |-> hostSerialOutput == $past(hostSerialInput, 2);
  endproperty
  a_ewrapData: assert property (p_ewrapData)
    else $error("electrical wrap data wrong");
endmodule : rsl_checker

`default_nettype wire

// [verification/tb.sv]
// self-checking bench: host and device ends joined by the link
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rsl_pkg::*;
  localparam int LD = 16;

  logic        core_clk       = 1'b0;
  logic        sys_rst        = 1'b1;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [11:0] paddr          = 12'h000;
  logic [31:0] pwdata         = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        opticalIn      = 1'b0;
  logic        opticalTopRate = 1'b1;
  logic        opticalOut;
  logic [2:0]  txEqSetting;
  logic [2:0]  rxEmphasisSetting;
  logic        rxLocked;
  logic        txLocked;
  logic        rxEngaged;
  logic        txEngaged;
  logic [3:0]  lockPins;
  logic [32:0] qExp;
  logic [32:0] qMsk;
  logic [32:0] expQ[$];
  logic [32:0] mskQ[$];
  logic [32:0] e0;
  logic [32:0] m0;
  logic [2:0]  modes[7] = '{3'b000, 3'b000, 3'b011, 3'b010,
                            3'b101, 3'b100, 3'b110};
  rsl_opts_t   o;
  int          badCount   = 0;
  int          checkCount = 0;
  int          cyc        = 0;
  int          seed       = 20;

  always #2.5 core_clk = ~core_clk;

  rsl_link_if link ();
  rsl_host rsl_host_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  rsl_device #(.LOCK_DELAY(LD)) rsl_device_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(link.device), .opticalIn(opticalIn),
    .opticalTopRate(opticalTopRate), .opticalOut(opticalOut),
    .rxLocked(rxLocked), .txLocked(txLocked), .rxEngaged(rxEngaged),
    .txEngaged(txEngaged),
    .txEqSetting(txEqSetting), .rxEmphasisSetting(rxEmphasisSetting));
  rsl_checker #(.LOCK_DELAY(LD)) rsl_checker_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .rxSpeedSelect(link.rxSpeedSelect),
    .txSpeedSelect(link.txSpeedSelect),
    .hostSerialInput(link.hostSerialInput),
    .hostTopRate(link.hostTopRate),
    .hostSerialOutput(link.hostSerialOutput),
    .ctrlValid(link.ctrlValid), .ctrlWord(link.ctrlWord),
    .devStatus(link.devStatus));

  assign lockPins = {txEngaged, rxEngaged, txLocked, rxLocked};

  // ---------------------------------------------------------------
  // checking and APB master
  // ---------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp,
                       input string what);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // the read result is noted before the transfer starts
  task automatic rd(input logic [11:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      stop_test();
    end else if (psel && penable && pready === 1'b1 && !pwrite) begin
      qExp = expQ.pop_front();
      qMsk = mskQ.pop_front();
      check({pslverr, prdata} & qMsk, qExp, "read");
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(REG_SELECT, 33'h0, 33'h1_ffff_ffff);
    rd(REG_OPTIONS, 33'h0, 33'h1_ffff_ffff);
    rd(REG_STATUS, 33'h0, 33'h1_ffff_ffff);
    rd(12'h010, 33'h1_0000_0000, 33'h1_ffff_ffff);
    apb(1'b1, REG_SELECT, 32'h3);
    repeat (10) @(posedge core_clk);
    check(33'(link.rxSpeedSelect), 33'h0, "rx select");
    rd(REG_STATUS, 33'h0, 33'hf);
    check(33'(lockPins), 33'h0, "lock pins");
    $display("test reset and undriven selects done");
    apb(1'b1, REG_DATA, 32'h0);
    apb(1'b1, REG_SELECT, 32'h7);
    repeat (40) @(posedge core_clk);
    rd(REG_STATUS, 33'hd, 33'hf);
    check(33'(lockPins), 33'hd, "lock pins");
    apb(1'b1, REG_DATA, 32'h2);
    repeat (40) @(posedge core_clk);
    rd(REG_STATUS, 33'hf, 33'hf);
    check(33'(lockPins), 33'hf, "lock pins");
    apb(1'b1, REG_SELECT, 32'h5);
    repeat (40) @(posedge core_clk);
    rd(REG_STATUS, 33'h5, 33'hf);
    check(33'(lockPins), 33'h5, "lock pins");
    // lower-rate traffic on the fibre must drop and keep off rx lock
    opticalTopRate <= 1'b0;
    repeat (40) @(posedge core_clk);
    rd(REG_STATUS, 33'h4, 33'hf);
    check(33'(lockPins), 33'h4, "lock pins");
    opticalTopRate <= 1'b1;
    apb(1'b1, REG_SELECT, 32'h4);
    apb(1'b1, REG_SELECT, 32'h5);
    repeat (8) @(posedge core_clk);
    rd(REG_STATUS, 33'h4, 33'h5);
    $display("test select and lock done");
    // first mode runs bypassed, the rest with recovery engaged
    foreach (modes[i]) begin
      apb(1'b1, REG_SELECT, (i == 0) ? 32'h4 : 32'h7);
      o = rsl_opts_t'({modes[i], 6'($random(seed))});
      apb(1'b1, REG_OPTIONS, 32'(o));
      repeat (4) @(posedge core_clk);
      check(33'(txEqSetting), 33'(o.txEq), "eq");
      check(33'(rxEmphasisSetting), 33'(o.rxEmphasis), "emph");
      repeat (4) begin
        opticalIn <= 1'($random(seed));
        apb(1'b1, REG_DATA, {30'h0, 1'b1, 1'($random(seed))});
        repeat (4) @(posedge core_clk);
        e0 = modes[i][1] ? 33'(pwdata[0]) :
             33'(modes[i][2] ? modes[i][0] & opticalIn : opticalIn);
        m0 = modes[i][2] ? 33'(opticalIn) :
             33'(modes[i][1] ? modes[i][0] & pwdata[0] : pwdata[0]);
        check(33'(opticalOut), m0, "optical out");
        rd(REG_DATA, e0 << 2, 33'h4);
      end
    end
    $display("test data paths and wraps done");
    stop_test();
  end
endmodule : tb

`default_nettype wire
